// ### include/cmp_pkg.sv
// constants, register map and mode decoding for the comparator control block
package cmp_pkg;

  // **********************************************************************
  // register indices (byte address is four times the index)
  // **********************************************************************
  localparam logic [7:0] IDX_INT_CTL = 8'h0b;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_CMP_CTL = 8'h19;
  localparam logic [7:0] IDX_PORT_VALUE = 8'h1a;
  localparam logic [7:0] IDX_PIN_DIR = 8'h85;
  localparam logic [7:0] IDX_IRQ_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_VREF_CTL = 8'h99;

  // **********************************************************************
  // field positions and write masks
  // **********************************************************************
  localparam int unsigned CC_RESULT_BIT = 6;
  localparam int unsigned CC_INVERT_BIT = 4;
  localparam int unsigned CC_SWITCH_BIT = 3;
  localparam logic [7:0] CC_WR_MASK = 8'h1f;
  localparam int unsigned IC_GLOBAL_BIT = 7;
  localparam int unsigned IC_PERIPH_BIT = 6;
  localparam int unsigned PF_CMP_BIT = 3;
  localparam int unsigned PE_CMP_BIT = 3;
  localparam int unsigned PD_PIN2_BIT = 2;
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned VR_POWER_BIT = 7;
  localparam int unsigned VR_RANGE_BIT = 5;
  localparam logic [7:0] VR_WR_MASK = 8'haf;

  // **********************************************************************
  // reset values
  // **********************************************************************
  localparam logic [7:0] RST_INT_CTL = 8'h00;
  localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
  localparam logic [7:0] RST_CMP_CTL = 8'h00;
  localparam logic [7:0] RST_PIN_DIR = 8'h3f;
  localparam logic [7:0] RST_IRQ_ENABLES = 8'h00;
  localparam logic [7:0] RST_VREF_CTL = 8'h00;

  // high range starts one quarter up a 32-step ladder
  localparam logic [4:0] VR_HIGH_BASE = 5'h08;

  // **********************************************************************
  // comparator modes
  // **********************************************************************
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [2:0] MODE_OUT_DIRECT = 3'h1;
  localparam logic [2:0] MODE_REF_INT = 3'h2;
  localparam logic [2:0] MODE_OUT_DIRECT2 = 3'h3;
  localparam logic [2:0] MODE_REF_INT2 = 3'h4;
  localparam logic [2:0] MODE_MUX_REF = 3'h5;
  localparam logic [2:0] MODE_MUX_REF_OUT = 3'h6;
  localparam logic [2:0] MODE_OFF = 3'h7;

  typedef struct packed {
    logic cmp_on;
    logic drives_pin;
    logic uses_ref;
    logic uses_switch;
    logic [2:0] analog_pins;
  } cmp_mode_cfg_t;

  function automatic cmp_mode_cfg_t mode_decode(input logic [2:0] mode);
    cmp_mode_cfg_t cfg;
    cfg.cmp_on = (mode != MODE_RESET) && (mode != MODE_OFF);
    cfg.drives_pin = (mode == MODE_OUT_DIRECT) || (mode == MODE_OUT_DIRECT2) ||
                     (mode == MODE_MUX_REF_OUT);
    cfg.uses_ref = (mode == MODE_REF_INT) || (mode == MODE_REF_INT2) ||
                   (mode == MODE_MUX_REF) || (mode == MODE_MUX_REF_OUT);
    cfg.uses_switch = (mode == MODE_MUX_REF) || (mode == MODE_MUX_REF_OUT);
    cfg.analog_pins = {mode == MODE_RESET, mode != MODE_OFF, mode != MODE_OFF};
    return cfg;
  endfunction

endpackage

// ### logic/cmp_sync.sv
// two-flop synchroniser for the raw comparator level
`timescale 1ns/10ps
`default_nettype none

module cmp_sync #(
  parameter int unsigned STAGES = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic async_in,
  output logic sync_out
);

  if (STAGES != 2) begin : g_stages_bad
    $error("cmp_sync supports exactly two stages");
  end

  logic meta_q;
  logic stable_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      stable_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule

`default_nettype wire

// ### logic/cmp_ctrl.sv
// comparator control, reference control and change interrupt with AHB-Lite registers
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - raw_compare is high when noninverting input exceeds inverting input
// - compare_result is raw comparison, complemented when output_invert is set
// - compare_mode selects one of eight routing configurations
// - compare_result reads at control bit 6 and ignores writes
// - three modes drive output_pin_two straight from the unsynchronised result
// - pin direction bit 2 enables output_pin_two in output modes
// - port value reads zero on every analog input pin
// - four modes connect the internal reference to a comparator input
// - reference control holds power bit 7, low range bit 5, level bits 3:0
// - reference tap is code of 24 low, or 8 plus code of 32 high
// - comparator and reference stay on in sleep; mode 111 turns off
// - enabled comparator interrupt wakes device, registers left unchanged
// - reset loads mode 000 and powers the reference down
// - flag sets while synced result differs from its latched value
// - flag clears only by writing 0; writing 1 sets it
// - request needs all three enables; flag sets regardless
// - any control access relatches the result; mismatch keeps setting flag
// - a change during a control read is caught, not missed
// - in modes 110 and 101 input_switch picks the inverting input pin
module cmp_ctrl #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic raw_compare,
  input wire logic [cmp_pkg::PIN_COUNT-1:0] port_pins,
  output logic cmp_enable,
  output logic inv_to_pos_pin,
  output logic noninv_from_ref,
  output logic ref_power_on,
  output logic ref_range_low,
  output logic [4:0] ref_tap,
  output logic output_pin_two,
  output logic output_pin_two_oe,
  output logic irq_request,
  output logic wake_request
);

  // elaboration check: the register index sits in haddr[9:2]
  if (ADDR_W < 10) begin : g_addr_too_narrow
    $error("cmp_ctrl needs at least ten address bits");
  end

  // **********************************************************************
  // bus slave: one-cycle address phase, zero wait data phase
  // **********************************************************************
  logic addr_take;
  logic [7:0] addr_idx;
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [31:0] hrdata_q;
  logic [7:0] rd_mux;

  logic [7:0] int_ctl_q;
  logic flag_q;
  logic [4:0] cmp_ctl_q;
  logic [cmp_pkg::PIN_COUNT-1:0] pin_dir_q;
  logic cmp_enable_q;
  logic [7:0] vref_q;
  logic latched_q;
  logic result_sync;
  logic cmp_result;
  logic mismatch;
  logic cmp_access;
  logic flag_wr;
  cmp_pkg::cmp_mode_cfg_t cfg;

  assign addr_take = hsel && hready && htrans[1];
  assign addr_idx = haddr[9:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_take && hwrite;
      wr_idx_q <= addr_idx;
    end
  end

  // read value is captured at the address phase and stands in the data phase
  always_comb begin
    rd_mux = 8'h00;
    case (addr_idx)
      cmp_pkg::IDX_INT_CTL: begin
        rd_mux = int_ctl_q;
      end
      cmp_pkg::IDX_IRQ_FLAGS: begin
        rd_mux[cmp_pkg::PF_CMP_BIT] = flag_q;
      end
      cmp_pkg::IDX_CMP_CTL: begin
        rd_mux = {1'b0, cmp_result, 1'b0, cmp_ctl_q};
      end
      cmp_pkg::IDX_PORT_VALUE: begin
        rd_mux = {2'b00, port_pins[5:3], port_pins[2:0] & ~cfg.analog_pins};
      end
      cmp_pkg::IDX_PIN_DIR: begin
        rd_mux = {2'b00, pin_dir_q};
      end
      cmp_pkg::IDX_IRQ_ENABLES: begin
        rd_mux[cmp_pkg::PE_CMP_BIT] = cmp_enable_q;
      end
      cmp_pkg::IDX_VREF_CTL: begin
        rd_mux = vref_q;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      hrdata_q <= {24'h00_0000, rd_mux};
    end
  end

  // **********************************************************************
  // software registers
  // **********************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_ctl_q <= cmp_pkg::RST_CMP_CTL[4:0];
    end else if (wr_pend_q && wr_idx_q == cmp_pkg::IDX_CMP_CTL) begin
      cmp_ctl_q <= hwdata[4:0] & cmp_pkg::CC_WR_MASK[4:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vref_q <= cmp_pkg::RST_VREF_CTL;
    end else if (wr_pend_q && wr_idx_q == cmp_pkg::IDX_VREF_CTL) begin
      vref_q <= hwdata[7:0] & cmp_pkg::VR_WR_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_ctl_q <= cmp_pkg::RST_INT_CTL;
    end else if (wr_pend_q && wr_idx_q == cmp_pkg::IDX_INT_CTL) begin
      int_ctl_q <= hwdata[7:0] & 8'hc0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_dir_q <= cmp_pkg::RST_PIN_DIR[cmp_pkg::PIN_COUNT-1:0];
    end else if (wr_pend_q && wr_idx_q == cmp_pkg::IDX_PIN_DIR) begin
      pin_dir_q <= hwdata[cmp_pkg::PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_enable_q <= cmp_pkg::RST_IRQ_ENABLES[cmp_pkg::PE_CMP_BIT];
    end else if (wr_pend_q && wr_idx_q == cmp_pkg::IDX_IRQ_ENABLES) begin
      cmp_enable_q <= hwdata[cmp_pkg::PE_CMP_BIT];
    end
  end

  // **********************************************************************
  // mode decode and analog steering
  // **********************************************************************
  assign cfg = cmp_pkg::mode_decode(cmp_ctl_q[2:0]);

  // no sleep input: nothing here powers down while the core sleeps
  assign cmp_enable = cfg.cmp_on;
  assign inv_to_pos_pin = cfg.uses_switch && cmp_ctl_q[cmp_pkg::CC_SWITCH_BIT];
  assign noninv_from_ref = cfg.uses_ref;
  assign ref_power_on = vref_q[cmp_pkg::VR_POWER_BIT];
  assign ref_range_low = vref_q[cmp_pkg::VR_RANGE_BIT];
  localparam logic [4:0] VR_HIGH_TAP_BASE = cmp_pkg::VR_HIGH_BASE;

  // low range taps a 24-step ladder, high range a 32-step ladder offset by 8
  assign ref_tap = ref_range_low ? {1'b0, vref_q[3:0]} :
                   (VR_HIGH_TAP_BASE + {1'b0, vref_q[3:0]});

  // **********************************************************************
  // result path and pin drive
  // **********************************************************************
  cmp_sync #(
    .STAGES(2)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(raw_compare),
    .sync_out(result_sync)
  );

  assign cmp_result = result_sync ^ cmp_ctl_q[cmp_pkg::CC_INVERT_BIT];

  // pin bypasses the synchroniser on purpose: no clock delay on the output
  assign output_pin_two = cfg.drives_pin &&
                          (raw_compare ^ cmp_ctl_q[cmp_pkg::CC_INVERT_BIT]);
  assign output_pin_two_oe = cfg.drives_pin && !pin_dir_q[cmp_pkg::PD_PIN2_BIT];

  // **********************************************************************
  // change detection and interrupt
  // **********************************************************************
  assign cmp_access = addr_take && addr_idx == cmp_pkg::IDX_CMP_CTL;
  assign mismatch = cfg.cmp_on && (cmp_result != latched_q);
  assign flag_wr = wr_pend_q && wr_idx_q == cmp_pkg::IDX_IRQ_FLAGS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched_q <= 1'b0;
    end else if (cmp_access || !cfg.cmp_on) begin
      latched_q <= cmp_result;
    end
  end

  // the mismatch of the relatch cycle still sets the flag, so nothing is missed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= cmp_pkg::RST_IRQ_FLAGS[cmp_pkg::PF_CMP_BIT];
    end else if (mismatch) begin
      flag_q <= 1'b1;
    end else if (flag_wr) begin
      flag_q <= hwdata[cmp_pkg::PF_CMP_BIT];
    end
  end

  assign irq_request = flag_q && cmp_enable_q && int_ctl_q[cmp_pkg::IC_PERIPH_BIT] &&
                       int_ctl_q[cmp_pkg::IC_GLOBAL_BIT];
  assign wake_request = flag_q && cmp_enable_q && int_ctl_q[cmp_pkg::IC_PERIPH_BIT];

  // **********************************************************************
  // assertions
  // **********************************************************************
  a_flag_sets: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mismatch |=> flag_q
  ) else $error("flag did not set on mismatch");

  a_flag_holds: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (flag_q && !flag_wr) |=> flag_q
  ) else $error("flag cleared without a write");

  a_flag_sw_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (flag_wr && hwdata[3]) |=> flag_q
  ) else $error("writing one did not set flag");

  a_irq_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    irq_request |-> (flag_q && cmp_enable_q && int_ctl_q[7] && int_ctl_q[6])
  ) else $error("request without all enables");

  a_relatch_ends: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (cmp_access && $stable(result_sync)) |=> (latched_q == $past(cmp_result))
  ) else $error("control access did not relatch");

  a_pin_enable: assert property (
    @(posedge hclk) disable iff (!hresetn)
    output_pin_two_oe |-> (cfg.drives_pin && !pin_dir_q[2])
  ) else $error("pin driven outside output mode");

  a_pin_value: assert property (
    @(posedge hclk) disable iff (!hresetn)
    output_pin_two_oe |-> (output_pin_two == (raw_compare ^ cmp_ctl_q[4]))
  ) else $error("pin value wrong");

  a_sync_delay: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $stable(cmp_ctl_q[cmp_pkg::CC_INVERT_BIT]) |->
      (cmp_result == ($past(raw_compare, 2) ^ cmp_ctl_q[cmp_pkg::CC_INVERT_BIT]))
  ) else $error("result not two cycles behind raw input");

  a_analog_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (addr_take && !hwrite && addr_idx == cmp_pkg::IDX_PORT_VALUE && cfg.analog_pins[0])
      |=> (hrdata[0] == 1'b0)
  ) else $error("analog pin read nonzero");

  a_ref_route: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (cmp_ctl_q[2:0] == 3'h2 || cmp_ctl_q[2:0] == 3'h6) |-> noninv_from_ref
  ) else $error("reference not routed");

  a_high_tap: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ref_range_low |-> (ref_tap == 5'(vref_q[3:0]) + 5'h08)
  ) else $error("high range tap wrong");

  a_result_read: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (cmp_access && !hwrite) |=> (hrdata[cmp_pkg::CC_RESULT_BIT] == $past(cmp_result))
  ) else $error("control read lost the result bit");

  a_flag_sw_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (flag_wr && !hwdata[cmp_pkg::PF_CMP_BIT] && !mismatch) |=> !flag_q
  ) else $error("writing zero did not clear flag");

  a_ctl_kept: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(wr_pend_q && wr_idx_q == cmp_pkg::IDX_CMP_CTL) |=> $stable(cmp_ctl_q)
  ) else $error("comparator control changed without a write");

  a_vref_kept: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(wr_pend_q && wr_idx_q == cmp_pkg::IDX_VREF_CTL) |=> $stable(vref_q)
  ) else $error("reference control changed without a write");

endmodule

`default_nettype wire

// ### verif/cmp_analog_model.sv
// analog side model: input pins, reference ladder and the comparator itself
`timescale 1ns/10ps
`default_nettype none

module cmp_analog_model (
  input wire logic cmp_enable,
  input wire logic inv_to_pos_pin,
  input wire logic noninv_from_ref,
  input wire logic ref_power_on,
  input wire logic ref_range_low,
  input wire logic [4:0] ref_tap,
  input wire logic [15:0] pos_mv,
  input wire logic [15:0] neg_mv,
  output logic raw_compare
);
  // ******************************
  // ladder and comparison in millivolts
  // ******************************
  localparam int VDD_MV = 3300;
  int ref_mv;
  int vp;
  int vm;

  always_comb begin
    ref_mv = 0;
    if (ref_power_on) begin
      ref_mv = ref_range_low ? ref_tap * VDD_MV / 24 : ref_tap * VDD_MV / 32;
    end
    vp = noninv_from_ref ? ref_mv : int'(pos_mv);
    vm = inv_to_pos_pin ? int'(pos_mv) : int'(neg_mv);
    // a powered-down comparator gives a steady low
    raw_compare = cmp_enable && (vp > vm);
  end
endmodule

`default_nettype wire

// ### verif/testbench.sv
// self-checking bench for the comparator control block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  // ******************************
  // stimulus and observed signals
  // ******************************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [5:0] port_pins = 6'h00;
  logic [15:0] pos_mv = 16'h07d0;
  logic [15:0] neg_mv = 16'h0064;
  logic [31:0] hrdata;
  logic hreadyout, hresp, raw_compare, cmp_enable, inv_to_pos_pin, noninv_from_ref;
  logic ref_power_on, ref_range_low, output_pin_two, output_pin_two_oe, irq_request;
  logic wake_request;
  logic [4:0] ref_tap;
  logic [15:0] lfsr = 16'h3c42;
  logic [31:0] rd;
  logic [2:0] m;
  logic input_switch, dir2, on, refm, pinm;
  logic [7:0] v, mask;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #12.5 hclk = ~hclk;

  cmp_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .raw_compare(raw_compare),
    .port_pins(port_pins), .cmp_enable(cmp_enable), .inv_to_pos_pin(inv_to_pos_pin),
    .noninv_from_ref(noninv_from_ref), .ref_power_on(ref_power_on),
    .ref_range_low(ref_range_low), .ref_tap(ref_tap), .output_pin_two(output_pin_two),
    .output_pin_two_oe(output_pin_two_oe), .irq_request(irq_request),
    .wake_request(wake_request));

  cmp_analog_model ana_u (.cmp_enable(cmp_enable), .inv_to_pos_pin(inv_to_pos_pin),
    .noninv_from_ref(noninv_from_ref), .ref_power_on(ref_power_on),
    .ref_range_low(ref_range_low), .ref_tap(ref_tap), .pos_mv(pos_mv), .neg_mv(neg_mv),
    .raw_compare(raw_compare));

  // ******************************
  // helpers
  // ******************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic print_verdict();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {2'b00, idx, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  task automatic reset_check();
    rdc(8'h0b, 8'h00);
    rdc(8'h0c, 8'h00);
    rdc(8'h19, 8'h00);
    rdc(8'h85, 8'h3f);
    rdc(8'h8c, 8'h00);
    rdc(8'h99, 8'h00);
    rdc(8'h40, 8'h00);
    chk({30'h0, cmp_enable, ref_power_on}, 32'h0);
    chk({30'h0, hreadyout, hresp}, 32'h2);
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  // ******************************
  // main sequence
  // ******************************
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    reset_check();
    wr(8'h19, 8'he7);
    rdc(8'h19, 8'h07);
    // every mode, switch and direction, with the interrupt masked throughout
    for (int i = 0; i < 32; i++) begin
      m = i[2:0];
      input_switch = i[3];
      dir2 = i[4];
      lfsr = lfsr_next(lfsr);
      port_pins <= lfsr[5:0];
      wr(8'h85, {5'h07, dir2, 2'h3});
      wr(8'h19, {4'h0, input_switch, m});
      on = (m != 3'h0) && (m != 3'h7);
      refm = (m == 3'h2) || (m == 3'h4) || (m == 3'h5) || (m == 3'h6);
      pinm = (m == 3'h1) || (m == 3'h3) || (m == 3'h6);
      mask = (m == 3'h0) ? 8'h07 : ((m == 3'h7) ? 8'h00 : 8'h03);
      rdc(8'h1a, {2'b00, lfsr[5:0]} & ~mask);
      chk({28'h0, cmp_enable, noninv_from_ref, output_pin_two, output_pin_two_oe},
          {28'h0, on, refm, pinm && !refm, pinm && !dir2});
      chk({31'h0, inv_to_pos_pin}, {31'h0, (m == 3'h5 || m == 3'h6) && input_switch});
    end
    // reference fields: boundary codes in both ranges, then random settings
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      v = lfsr[7:0] | 8'h80;
      if (i < 4) v = {2'b10, i[1], 1'b0, {4{i[0]}}};
      wr(8'h99, v);
      rdc(8'h99, v & 8'haf);
      chk({25'h0, ref_power_on, ref_range_low, ref_tap},
          {25'h0, 1'b1, v[5], v[5] ? {1'b0, v[3:0]} : 5'h08 + {1'b0, v[3:0]}});
    end
    wr(8'h99, 8'h00);
    rdc(8'h99, 8'h00);
    chk({31'h0, ref_power_on}, 32'h0);
    // change interrupt against the reference at a quarter of supply
    @(posedge hclk);
    neg_mv <= 16'h07d0;
    wr(8'h99, 8'h80);
    wr(8'h19, 8'h02);
    repeat (4) @(posedge hclk);
    rdc(8'h19, 8'h02);
    wr(8'h0c, 8'h00);
    rdc(8'h0c, 8'h00);
    wr(8'h0b, 8'hc0);
    wr(8'h8c, 8'h08);
    rdc(8'h0b, 8'hc0);
    @(posedge hclk);
    neg_mv <= 16'h0064;
    repeat (4) @(posedge hclk);
    rdc(8'h0c, 8'h08);
    chk({31'h0, irq_request}, 32'h1);
    wr(8'h0c, 8'h00);
    rdc(8'h0c, 8'h08);
    rdc(8'h19, 8'h42);
    wr(8'h0c, 8'h00);
    rdc(8'h0c, 8'h00);
    chk({31'h0, irq_request}, 32'h0);
    wr(8'h19, 8'h52);
    rdc(8'h19, 8'h12);
    wr(8'h0c, 8'h00);
    rdc(8'h0c, 8'h00);
    wr(8'h0c, 8'h08);
    rdc(8'h0c, 8'h08);
    chk({31'h0, irq_request}, 32'h1);
    wr(8'h0b, 8'h40);
    rdc(8'h0b, 8'h40);
    chk({30'h0, irq_request, wake_request}, 32'h1);
    wr(8'h8c, 8'h00);
    rdc(8'h0c, 8'h08);
    chk({31'h0, wake_request}, 32'h0);
    rdc(8'h19, 8'h12);
    rdc(8'h99, 8'h80);
    // second reset in mid-run
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    reset_check();
    print_verdict();
  end
endmodule

`default_nettype wire
